// ==== audio_clock_pkg.sv ====
// Purpose: Shared constants for the field-locked audio clock generator.
// Assumes: Byte-wide registers at their printed subaddresses.
// Notes:   Reset values of the audio registers are zero.
`default_nettype none

package audio_clock_pkg;

    // Register subaddresses
    localparam logic [7:0] OFS_CPF_LOW    = 8'h30;
    localparam logic [7:0] OFS_CPF_MID    = 8'h31;
    localparam logic [7:0] OFS_CPF_HIGH   = 8'h32;
    localparam logic [7:0] OFS_INC_LOW    = 8'h34;
    localparam logic [7:0] OFS_INC_MID    = 8'h35;
    localparam logic [7:0] OFS_INC_HIGH   = 8'h36;
    localparam logic [7:0] OFS_BIT_RATIO  = 8'h38;
    localparam logic [7:0] OFS_CHAN_RATIO = 8'h39;
    localparam logic [7:0] OFS_CONTROL    = 8'h3a;
    localparam logic [7:0] OFS_STATUS     = 8'h3b;

    // Field widths
    localparam int CPF_W  = 18;
    localparam int INC_W  = 22;
    localparam int DIV_W  = 6;
    localparam int CTRL_W = 4;
    localparam int ACC_W  = 23;
    localparam int CORR_W = 8;
    localparam int SYNC_N = 3;

    // Byte lanes of the multi-byte fields
    localparam int MID_LSB  = 8;
    localparam int HIGH_LSB = 16;

    // Control bit positions
    localparam int CTRL_LOOP_OPEN = 3;
    localparam int CTRL_VREF_SRC  = 2;
    localparam int CTRL_CHAN_PH   = 1;
    localparam int CTRL_BIT_PH    = 0;

    // Reset values
    localparam logic [CPF_W-1:0]  CPF_RST  = 18'h00000;
    localparam logic [INC_W-1:0]  INC_RST  = 22'h000000;
    localparam logic [DIV_W-1:0]  DIV_RST  = 6'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [7:0]        BYTE_ZERO = 8'h00;
    localparam logic [ACC_W-1:0]  ACC_RST  = 23'h000000;

    // Loop correction limits
    localparam logic signed [CORR_W-1:0] CORR_ZERO = 8'sh00;
    localparam logic signed [CORR_W-1:0] CORR_MAX  = 8'sh7f;
    localparam logic signed [CORR_W-1:0] CORR_MIN  = -8'sh7f;
    localparam logic signed [CORR_W-1:0] CORR_STEP = 8'sh01;

endpackage

`default_nettype wire

// ==== audio_clock_gen.sv ====
// Purpose: Field-locked audio master, bit and channel-select clock generator.
// Assumes: clk_sys 125 MHz; audio_master_clock_in is an unrelated second clock.
// Notes:   Bit and channel clocks leave a two-flop mux, one flop per master clock edge.
// Contract
// - Hold 18-bit cycles-per-field count over three bytes, low two bits of third.
// - Hold 22-bit nominal increment over three bytes, low six bits of third.
// - Bit clock divides the master clock input by a 6-bit ratio.
// - Channel-select clock divides the bit clock by a second 6-bit ratio.
// - Loop-open bit 0 keeps the loop closed, master clock locked to field.
// - Loop-open bit 1 lets the master clock run free.
// - Vertical-reference source 0 takes the internal decoder pulse.
// - Vertical-reference source 1 takes the expansion-port reference input.
// - Channel edge phase 0: channel clock changes on bit clock falling edges.
// - Channel edge phase 1: channel clock changes on bit clock rising edges.
// - Bit edge phase 0: bit clock changes on master clock falling edges.
// - Bit edge phase 1: bit clock changes on master clock rising edges.
`timescale 1ns/1ps
`default_nettype none

module audio_clock_gen
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       audio_master_clock_in,
    input  wire logic       vref_internal,
    input  wire logic       expansion_vertical_ref,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rd_data,
    output logic            audio_master_clock_out,
    output logic            audio_bit_clock,
    output logic            audio_channel_select_clock
);

    import audio_clock_pkg::*;

    // System domain state
    logic [CPF_W-1:0]         cpf_reg, cpf_next;
    logic [INC_W-1:0]         inc_reg, inc_next;
    logic [DIV_W-1:0]         bdiv_reg, bdiv_next;
    logic [DIV_W-1:0]         cdiv_reg, cdiv_next;
    logic [CTRL_W-1:0]        ctrl_reg, ctrl_next;
    logic [7:0]               rd_data_reg, rd_data_next;
    logic [SYNC_N-1:0]        xrv_sync_reg;
    logic                     xrv_level_reg, xrv_level_next;
    logic                     vref_prev_reg;
    logic [ACC_W-1:0]         acc_reg, acc_next;
    logic [CPF_W-1:0]         field_cnt_reg, field_cnt_next;
    logic signed [CORR_W-1:0] corr_reg, corr_next;
    logic                     lock_reg, lock_next;
    logic                     cfg_tog_reg, cfg_tog_next;
    logic                     vref_sel;
    logic                     vref_edge;
    logic                     mclk_rise;
    logic [INC_W-1:0]         inc_eff;
    logic [CPF_W-1:0]         field_total;

    // Selected vertical reference and its leading edge
    always_comb
    begin
        vref_sel    = ctrl_reg[CTRL_VREF_SRC] ? xrv_level_reg : vref_internal;
        vref_edge   = vref_sel & ~vref_prev_reg;
        inc_eff     = inc_reg + INC_W'(corr_reg);
        acc_next    = acc_reg + ACC_W'(inc_eff);
        mclk_rise   = acc_next[ACC_W-1] & ~acc_reg[ACC_W-1];
        field_total = field_cnt_reg + CPF_W'(mclk_rise);
    end

    // Register writes, readback and the field-lock loop
    always_comb
    begin
        cpf_next       = cpf_reg;
        inc_next       = inc_reg;
        bdiv_next      = bdiv_reg;
        cdiv_next      = cdiv_reg;
        ctrl_next      = ctrl_reg;
        rd_data_next   = rd_data_reg;
        cfg_tog_next   = cfg_tog_reg;
        corr_next      = corr_reg;
        lock_next      = lock_reg;
        field_cnt_next = field_total;
        // A change only counts once the second and third stages agree
        xrv_level_next = (xrv_sync_reg[1] == xrv_sync_reg[2]) ? xrv_sync_reg[2]
                                                               : xrv_level_reg;
        if (reg_wr)
        begin
            unique case (reg_addr)
                OFS_CPF_LOW:    cpf_next[MID_LSB-1:0]        = reg_wr_data;
                OFS_CPF_MID:    cpf_next[HIGH_LSB-1:MID_LSB] = reg_wr_data;
                OFS_CPF_HIGH:   cpf_next[CPF_W-1:HIGH_LSB]   = reg_wr_data[CPF_W-HIGH_LSB-1:0];
                OFS_INC_LOW:    inc_next[MID_LSB-1:0]        = reg_wr_data;
                OFS_INC_MID:    inc_next[HIGH_LSB-1:MID_LSB] = reg_wr_data;
                OFS_INC_HIGH:   inc_next[INC_W-1:HIGH_LSB]   = reg_wr_data[INC_W-HIGH_LSB-1:0];
                OFS_BIT_RATIO:
                begin
                    bdiv_next    = reg_wr_data[DIV_W-1:0];
                    cfg_tog_next = ~cfg_tog_reg;
                end
                OFS_CHAN_RATIO:
                begin
                    cdiv_next    = reg_wr_data[DIV_W-1:0];
                    cfg_tog_next = ~cfg_tog_reg;
                end
                OFS_CONTROL:
                begin
                    ctrl_next    = reg_wr_data[CTRL_W-1:0];
                    cfg_tog_next = ~cfg_tog_reg;
                end
                default:        cpf_next = cpf_reg;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_CPF_LOW:    rd_data_next = cpf_reg[MID_LSB-1:0];
                OFS_CPF_MID:    rd_data_next = cpf_reg[HIGH_LSB-1:MID_LSB];
                OFS_CPF_HIGH:   rd_data_next = 8'(cpf_reg[CPF_W-1:HIGH_LSB]);
                OFS_INC_LOW:    rd_data_next = inc_reg[MID_LSB-1:0];
                OFS_INC_MID:    rd_data_next = inc_reg[HIGH_LSB-1:MID_LSB];
                OFS_INC_HIGH:   rd_data_next = 8'(inc_reg[INC_W-1:HIGH_LSB]);
                OFS_BIT_RATIO:  rd_data_next = 8'(bdiv_reg);
                OFS_CHAN_RATIO: rd_data_next = 8'(cdiv_reg);
                OFS_CONTROL:    rd_data_next = 8'(ctrl_reg);
                OFS_STATUS:     rd_data_next = 8'(lock_reg);
                default:        rd_data_next = BYTE_ZERO;
            endcase
        end
        // Loop steers the increment by one step per field; slow but glitch free
        if (ctrl_reg[CTRL_LOOP_OPEN])
        begin
            corr_next = CORR_ZERO;
            lock_next = 1'b0;
        end
        else if (vref_edge)
        begin
            lock_next = (field_total == cpf_reg);
            if (field_total < cpf_reg && corr_reg != CORR_MAX)
                corr_next = corr_reg + CORR_STEP;
            else if (field_total > cpf_reg && corr_reg != CORR_MIN)
                corr_next = corr_reg - CORR_STEP;
        end
        if (vref_edge)
            field_cnt_next = CPF_W'(mclk_rise);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpf_reg       <= CPF_RST;
            inc_reg       <= INC_RST;
            bdiv_reg      <= DIV_RST;
            cdiv_reg      <= DIV_RST;
            ctrl_reg      <= CTRL_RST;
            rd_data_reg   <= BYTE_ZERO;
            xrv_sync_reg  <= '0;
            xrv_level_reg <= 1'b0;
            vref_prev_reg <= 1'b0;
            acc_reg       <= ACC_RST;
            field_cnt_reg <= CPF_RST;
            corr_reg      <= CORR_ZERO;
            lock_reg      <= 1'b0;
            cfg_tog_reg   <= 1'b0;
        end
        else
        begin
            cpf_reg       <= cpf_next;
            inc_reg       <= inc_next;
            bdiv_reg      <= bdiv_next;
            cdiv_reg      <= cdiv_next;
            ctrl_reg      <= ctrl_next;
            rd_data_reg   <= rd_data_next;
            xrv_sync_reg  <= {xrv_sync_reg[SYNC_N-2:0], expansion_vertical_ref};
            xrv_level_reg <= xrv_level_next;
            vref_prev_reg <= vref_sel;
            acc_reg       <= acc_next;
            field_cnt_reg <= field_cnt_next;
            corr_reg      <= corr_next;
            lock_reg      <= lock_next;
            cfg_tog_reg   <= cfg_tog_next;
        end
    end

    assign reg_rd_data            = rd_data_reg;
    assign audio_master_clock_out = acc_reg[ACC_W-1];

    // Audio domain state, clocked by the master clock input
    logic [SYNC_N-1:0] cfg_sync_reg;
    logic              cfg_seen_reg, cfg_seen_next;
    logic [DIV_W-1:0]  bdiv_a_reg, bdiv_a_next;
    logic [DIV_W-1:0]  cdiv_a_reg, cdiv_a_next;
    logic              chan_ph_reg, chan_ph_next;
    logic              bit_ph_reg, bit_ph_next;
    logic [DIV_W-1:0]  bit_cnt_reg, bit_cnt_next;
    logic              bclk_reg, bclk_next;
    logic [DIV_W-1:0]  lr_cnt_reg, lr_cnt_next;
    logic              lrclk_reg, lrclk_next;
    logic              bclk_fall_reg;
    logic              lrclk_fall_reg;

    // Config words are held still while the toggle crosses, then sampled
    always_comb
    begin
        cfg_seen_next = cfg_seen_reg;
        bdiv_a_next   = bdiv_a_reg;
        cdiv_a_next   = cdiv_a_reg;
        chan_ph_next  = chan_ph_reg;
        bit_ph_next   = bit_ph_reg;
        bit_cnt_next  = bit_cnt_reg + 6'h01;
        bclk_next     = bclk_reg;
        lr_cnt_next   = lr_cnt_reg;
        lrclk_next    = lrclk_reg;
        if (cfg_sync_reg[1] == cfg_sync_reg[2] && cfg_sync_reg[2] != cfg_seen_reg)
        begin
            cfg_seen_next = cfg_sync_reg[2];
            bdiv_a_next   = bdiv_reg;
            cdiv_a_next   = cdiv_reg;
            chan_ph_next  = ctrl_reg[CTRL_CHAN_PH];
            bit_ph_next   = ctrl_reg[CTRL_BIT_PH];
        end
        if (bit_cnt_reg >= bdiv_a_reg)
        begin
            bit_cnt_next = DIV_RST;
            bclk_next    = ~bclk_reg;
            // Channel clock steps only on the chosen bit clock edge
            if (bclk_next == chan_ph_reg)
            begin
                if (lr_cnt_reg >= cdiv_a_reg)
                begin
                    lr_cnt_next = DIV_RST;
                    lrclk_next  = ~lrclk_reg;
                end
                else
                    lr_cnt_next = lr_cnt_reg + 6'h01;
            end
        end
    end

    always_ff @(posedge audio_master_clock_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_sync_reg <= '0;
            cfg_seen_reg <= 1'b0;
            bdiv_a_reg   <= DIV_RST;
            cdiv_a_reg   <= DIV_RST;
            chan_ph_reg  <= CTRL_RST[CTRL_CHAN_PH];
            bit_ph_reg   <= CTRL_RST[CTRL_BIT_PH];
            bit_cnt_reg  <= DIV_RST;
            bclk_reg     <= 1'b0;
            lr_cnt_reg   <= DIV_RST;
            lrclk_reg    <= 1'b0;
        end
        else
        begin
            cfg_sync_reg <= {cfg_sync_reg[SYNC_N-2:0], cfg_tog_reg};
            cfg_seen_reg <= cfg_seen_next;
            bdiv_a_reg   <= bdiv_a_next;
            cdiv_a_reg   <= cdiv_a_next;
            chan_ph_reg  <= chan_ph_next;
            bit_ph_reg   <= bit_ph_next;
            bit_cnt_reg  <= bit_cnt_next;
            bclk_reg     <= bclk_next;
            lr_cnt_reg   <= lr_cnt_next;
            lrclk_reg    <= lrclk_next;
        end
    end

    // Half-cycle retimed copy for the falling-edge phase
    always_ff @(negedge audio_master_clock_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bclk_fall_reg  <= 1'b0;
            lrclk_fall_reg <= 1'b0;
        end
        else
        begin
            bclk_fall_reg  <= bclk_reg;
            lrclk_fall_reg <= lrclk_reg;
        end
    end

    // Both outputs switch on the same master clock edge
    assign audio_bit_clock            = bit_ph_reg ? bclk_reg : bclk_fall_reg;
    assign audio_channel_select_clock = bit_ph_reg ? lrclk_reg : lrclk_fall_reg;

    // System domain checks
    cpf_low_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == OFS_CPF_LOW |=> cpf_reg[7:0] == $past(reg_wr_data))
        else $error("cycles-per-field low byte not stored");
    inc_high_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == OFS_INC_HIGH
        |=> inc_reg[INC_W-1:HIGH_LSB] == $past(reg_wr_data[5:0]))
        else $error("increment high bits not stored");
    upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_rd && (reg_addr == OFS_CPF_HIGH || reg_addr == OFS_BIT_RATIO)
        |=> reg_rd_data[7:6] == 2'h0)
        else $error("unused upper bits read nonzero");
    loop_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctrl_reg[CTRL_LOOP_OPEN] |=> corr_reg == CORR_ZERO && !lock_reg)
        else $error("open loop still corrects");
    loop_pull_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ctrl_reg[CTRL_LOOP_OPEN] && vref_edge && field_total < cpf_reg
        && corr_reg != CORR_MAX |=> corr_reg == $past(corr_reg) + CORR_STEP)
        else $error("closed loop did not speed up");
    vref_int_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ctrl_reg[CTRL_VREF_SRC] && vref_internal && !vref_prev_reg
        |=> field_cnt_reg <= 18'h00001)
        else $error("internal reference did not start field");
    vref_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctrl_reg[CTRL_VREF_SRC] && xrv_level_reg && !vref_prev_reg
        |=> field_cnt_reg <= 18'h00001)
        else $error("expansion reference did not start field");
    // Audio domain checks; a new config may land on the same edge as a step
    bit_div_a: assert property (@(posedge audio_master_clock_in) disable iff (!rst_b)
        bit_cnt_reg < bdiv_a_reg |=> $stable(bclk_reg))
        else $error("bit clock toggled early");
    chan_div_a: assert property (@(posedge audio_master_clock_in) disable iff (!rst_b)
        $changed(lrclk_reg)
        |-> bclk_reg == $past(chan_ph_reg) && $past(lr_cnt_reg) >= $past(cdiv_a_reg))
        else $error("channel clock on wrong edge or count");
    bit_fall_a: assert property (@(posedge audio_master_clock_in) disable iff (!rst_b)
        !bit_ph_reg |-> audio_bit_clock == bclk_reg && audio_channel_select_clock == lrclk_reg)
        else $error("falling-phase copy out of step");
    bit_rise_a: assert property (@(posedge audio_master_clock_in) disable iff (!rst_b)
        bit_ph_reg && $changed(bclk_reg) |-> audio_bit_clock != $past(audio_bit_clock))
        else $error("rising phase output late");
    lock_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(lock_reg));
    ext_field_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        ctrl_reg[CTRL_VREF_SRC] && vref_edge);
    chan_flip_c: cover property (@(posedge audio_master_clock_in) disable iff (!rst_b)
        $changed(lrclk_reg) && chan_ph_reg);

endmodule

`default_nettype wire

// ==== audio_codec_model.sv ====
// Purpose: Behavioural audio converter clocked by the generated audio clocks.
// Assumes: Every audio clock half period is far longer than 2 ns.
// Notes:   Reports measured ratios and the edge on which each clock changes.
`timescale 1ns/1ps
`default_nettype none

module audio_codec_model
(
    input  wire logic mclk,
    input  wire logic bit_clk,
    input  wire logic chan_clk,
    output var  int   master_per_bit,
    output var  int   bits_per_chan,
    output var  logic bit_on_rise,
    output var  logic chan_on_rise,
    output var  int   chan_toggles
);
    int m_cnt = 0;
    int b_cnt = 0;

    initial
    begin
        chan_toggles = 0;
    end

    // Master rising edges seen within one bit clock half period
    always @(posedge mclk)
        m_cnt = m_cnt + 1;

    // Latch late so that an edge coincident with the change is counted first
    always @(bit_clk)
    begin
        b_cnt = b_cnt + 1;
        #1;
        master_per_bit = m_cnt;
        m_cnt = 0;
        bit_on_rise = mclk;
    end

    // Bit clock edges within one channel half period, and the launching edge
    always @(chan_clk)
    begin
        #2;
        bits_per_chan = b_cnt;
        b_cnt = 0;
        chan_on_rise = bit_clk;
        chan_toggles = chan_toggles + 1;
    end
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the field-locked audio clock generator.
// Assumes: Master clock input is free running and unrelated to clk_sys.
// Notes:   Random ratios from a fixed seed, with corner ratios first.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end

module testbench;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b1;
    logic       audio_master_clock_in = 1'b0;
    logic       vref_internal = 1'b0;
    logic       expansion_vertical_ref = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rd_data;
    logic       audio_master_clock_out;
    logic       audio_bit_clock;
    logic       audio_channel_select_clock;
    int         master_per_bit;
    int         bits_per_chan;
    logic       bit_on_rise;
    logic       chan_on_rise;
    int         chan_toggles;
    int         n_fail = 0;
    int         n_compared = 0;
    int         int_per = 800;
    int         exp_per = 880;
    int         int_cnt = 0;
    int         exp_cnt = 0;
    logic [7:0] reg_list [12] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36,
                                  8'h38, 8'h39, 8'h3a, 8'h33, 8'h37, 8'h3c};

    always #4 clk_sys = ~clk_sys;

    // Master clock input with an odd phase offset against clk_sys
    initial
    begin
        #3.7;
        forever #24 audio_master_clock_in = ~audio_master_clock_in;
    end

    // Two field references of different length, four cycles high each
    always @(posedge clk_sys)
    begin
        #1;
        int_cnt = (int_cnt >= int_per - 1) ? 0 : int_cnt + 1;
        exp_cnt = (exp_cnt >= exp_per - 1) ? 0 : exp_cnt + 1;
        vref_internal = (int_cnt < 4);
        expansion_vertical_ref = (exp_cnt < 4);
    end

    audio_clock_gen u_audio_clock_gen
    (
        .clk_sys                    (clk_sys),
        .rst_b                      (rst_b),
        .audio_master_clock_in      (audio_master_clock_in),
        .vref_internal              (vref_internal),
        .expansion_vertical_ref     (expansion_vertical_ref),
        .reg_addr                   (reg_addr),
        .reg_wr                     (reg_wr),
        .reg_wr_data                (reg_wr_data),
        .reg_rd                     (reg_rd),
        .reg_rd_data                (reg_rd_data),
        .audio_master_clock_out     (audio_master_clock_out),
        .audio_bit_clock            (audio_bit_clock),
        .audio_channel_select_clock (audio_channel_select_clock)
    );

    audio_codec_model u_audio_codec_model
    (
        .mclk           (audio_master_clock_in),
        .bit_clk        (audio_bit_clock),
        .chan_clk       (audio_channel_select_clock),
        .master_per_bit (master_per_bit),
        .bits_per_chan  (bits_per_chan),
        .bit_on_rise    (bit_on_rise),
        .chan_on_rise   (chan_on_rise),
        .chan_toggles   (chan_toggles)
    );

    // Implemented bits of each byte; unmapped places read zero
    function automatic logic [7:0] exp_byte(logic [7:0] a, logic [7:0] d);
        case (a)
            8'h30, 8'h31, 8'h34, 8'h35: return d;
            8'h32: return d & 8'h03;
            8'h36, 8'h38, 8'h39: return d & 8'h3f;
            8'h3a: return d & 8'h0f;
            default: return 8'h00;
        endcase
    endfunction

    task automatic close_out;
        $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A real falling edge, so both clock domains reset at once
    task automatic do_reset;
        #1 rst_b = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 rst_b = 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
        @(posedge clk_sys);
        #1 d = reg_rd_data;
    endtask

    // Bounded wait for fresh channel clock toggles
    task automatic wait_toggles(input int n);
        int start;
        start = chan_toggles;
        for (int i = 0; i < 20000 && chan_toggles < start + n; i++)
            @(posedge clk_sys);
        if (chan_toggles < start + n)
        begin
            n_fail++;
            close_out();
        end
    endtask

    // clk_sys cycles between two rises of the master clock output, sampled off the edge
    task automatic mclk_period(output int p);
        p = 0;
        for (int i = 0; i < 200 && !(audio_master_clock_out === 1'b0); i++)
            @(posedge clk_sys) #1;
        for (int i = 0; i < 200 && !(audio_master_clock_out === 1'b1); i++)
            @(posedge clk_sys) #1;
        // High half, then low half
        for (int i = 0; i < 200 && !(audio_master_clock_out === 1'b0); i++)
        begin
            @(posedge clk_sys) #1;
            p++;
        end
        for (int i = 0; i < 200 && !(audio_master_clock_out === 1'b1); i++)
        begin
            @(posedge clk_sys) #1;
            p++;
        end
    endtask

    // Nominal step of 2^20 gives one master period every 8 clk_sys cycles
    task automatic setup_loop;
        wr(8'h34, 8'h00);
        wr(8'h35, 8'h00);
        wr(8'h36, 8'hd0);
        wr(8'h30, 8'h64);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'hfc);
    endtask

    task automatic check_lock(input logic [3:0] ctrl, input logic exp);
        logic [7:0] d;
        wr(8'h3a, {4'h0, ctrl});
        repeat (4 * 880) @(posedge clk_sys);
        rd(8'h3b, d);
        `CHECK(d[0], exp);
    endtask

    initial
    begin
        logic [7:0] d;
        logic [7:0] w;
        logic [1:0] ph;
        int         p;
        int         r;
        int         c;
        void'($urandom(32'h32741ad9));
        do_reset();
        // Reset values, then one random write per register, upper bits included
        foreach (reg_list[i])
        begin
            rd(reg_list[i], d);
            `CHECK(d, 8'h00);
        end
        foreach (reg_list[i])
        begin
            w = 8'($urandom);
            wr(reg_list[i], w);
            rd(reg_list[i], d);
            `CHECK(d, exp_byte(reg_list[i], w));
        end
        // Ratios and edge phases: corners first, then random
        for (int i = 0; i < 7; i++)
        begin
            ph = 2'(i);
            r = (i == 1) ? 63 : (i < 3) ? 0 : int'($urandom % 8);
            c = (i == 2) ? 63 : (i < 3) ? 0 : int'($urandom % 8);
            wr(8'h38, {2'($urandom), 6'(r)});
            wr(8'h39, {2'($urandom), 6'(c)});
            wr(8'h3a, {6'h00, ph});
            wait_toggles(4);
            `CHECK(master_per_bit, r + 1);
            `CHECK(bits_per_chan, 2 * (c + 1));
            `CHECK(bit_on_rise, ph[0]);
            `CHECK(chan_on_rise, ph[1]);
        end
        // Free-running master clock keeps its nominal period
        setup_loop();
        wr(8'h3a, 8'h08);
        mclk_period(p);
        `CHECK(p, 8);
        check_lock(4'h8, 1'b0);
        check_lock(4'h0, 1'b1);
        check_lock(4'h4, 1'b0);
        // Second reset mid-run, then the expansion reference carries the field
        do_reset();
        rd(8'h3a, d);
        `CHECK(d, 8'h00);
        int_per = 880;
        exp_per = 800;
        setup_loop();
        check_lock(4'h4, 1'b1);
        check_lock(4'h0, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
